/* File: design/sysref_out_pkg.sv */
// Shared constants and carriers for the reference-signal output state bank.
// Assumes one 125 MHz clock domain; used by the bank and its per-channel gate.
package sysref_out_pkg;

  // Channel count and channel positions in the bank
  localparam int NUM_CH = 7;
  localparam logic [2:0] CH_A0 = 3'h0;
  localparam logic [2:0] CH_A1 = 3'h1;
  localparam logic [2:0] CH_A2 = 3'h2;
  localparam logic [2:0] CH_B0 = 3'h3;
  localparam logic [2:0] CH_B1 = 3'h4;
  localparam logic [2:0] CH_C = 3'h5;
  localparam logic [2:0] CH_D = 3'h6;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CFG_W = 10;

  // Register byte addresses: one word per channel, then a status word
  localparam logic [7:0] CFG_BASE_ADDR = 8'h00;
  localparam logic [7:0] CFG_LAST_ADDR = 8'h18;
  localparam logic [7:0] STATUS_ADDR = 8'h1c;
  localparam int WORD_LSB = 2;
  localparam int STATUS_BIAS_TYPE_BIT = 8;

  // Swing codes
  localparam logic [1:0] SWING_250MV = 2'h0;
  localparam logic [1:0] SWING_500MV = 2'h1;
  localparam logic [1:0] SWING_750MV = 2'h2;
  localparam logic [1:0] SWING_1000MV = 2'h3;

  // Driver format
  localparam logic STYLE_LVDS = 1'h0;
  localparam logic STYLE_LVPECL = 1'h1;

  // Source select
  localparam logic SRC_OWN_CLOCK = 1'h0;
  localparam logic SRC_SYSREF = 1'h1;

  // Delay figures in picoseconds
  localparam int COARSE_STEP_PS = 169;
  localparam int DELAY_W = 11;

  // Per-channel configuration word, bit 0 upward: fine, src, bias, style, swing, pd, en
  typedef struct packed {
    logic enable;
    logic powerdown;
    logic [1:0] swing;
    logic style;
    logic bias_on;
    logic src_sel;
    logic [2:0] fine;
  } chan_cfg_t;

  localparam chan_cfg_t CFG_RESET = '{
    enable: 1'h0, powerdown: 1'h0, swing: SWING_250MV, style: STYLE_LVDS,
    bias_on: 1'h0, src_sel: SRC_SYSREF, fine: 3'h0};

  // Effective control handed to the analog driver of one channel
  typedef struct packed {
    logic powered;
    logic level;
    logic style;
    logic [1:0] swing;
    logic bias_active;
    logic [DELAY_W-1:0] delay_ps;
  } chan_out_t;

  localparam chan_out_t OUT_RESET = '{
    powered: 1'h0, level: 1'h0, style: STYLE_LVDS, swing: SWING_250MV,
    bias_active: 1'h0, delay_ps: 11'h000};

  // Fine step decode; the steps are not uniform past code 3
  function automatic logic [DELAY_W-1:0] fine_delay_ps(input logic [2:0] code);
    logic [DELAY_W-1:0] ps;
    ps = 11'h000;
    case (code)
      3'h0: ps = 11'd0;
      3'h1: ps = 11'd25;
      3'h2: ps = 11'd50;
      3'h3: ps = 11'd75;
      3'h4: ps = 11'd85;
      3'h5: ps = 11'd110;
      3'h6: ps = 11'd135;
      default: ps = 11'd160;
    endcase
    return ps;
  endfunction

endpackage

/* File: design/sysref_chan_gate.sv */
// Effective output control for one reference-signal channel.
// Assumes configuration and source signals come from logic on the same clock.
`timescale 1ns/1ns
module sysref_chan_gate (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Configuration
  input wire sysref_out_pkg::chan_cfg_t cfg,
  input wire logic [2:0] coarse_delay,
  input wire logic bias_type,
  // Signal sources
  input wire logic own_clock,
  input wire logic sysref_pulse,
  // Effective control
  output sysref_out_pkg::chan_out_t drv
);

  typedef struct packed {
    sysref_out_pkg::chan_out_t drv;
  } gate_state_t;

  gate_state_t state_ff;
  gate_state_t nxt_state;
  logic selected;
  logic [sysref_out_pkg::DELAY_W-1:0] coarse_ps;

  // Source mux and coarse delay in ps
  assign selected = (cfg.src_sel == sysref_out_pkg::SRC_SYSREF) ? sysref_pulse : own_clock;
  assign coarse_ps = sysref_out_pkg::DELAY_W'(coarse_delay * sysref_out_pkg::COARSE_STEP_PS);

  // Power-down wins, then enable gating, then the shaping fields
  always_comb begin
    nxt_state = '{drv: sysref_out_pkg::OUT_RESET};
    if (cfg.powerdown) begin
      nxt_state.drv = sysref_out_pkg::OUT_RESET;
    end else begin
      nxt_state.drv.powered = 1'h1;
      nxt_state.drv.level = cfg.enable ? selected : 1'h0;
      nxt_state.drv.style = cfg.style;
      nxt_state.drv.swing = cfg.swing;
      nxt_state.drv.bias_active = cfg.bias_on & bias_type;
      // Sum tops out at 1343 ps, so the cut to the field width loses nothing
      nxt_state.drv.delay_ps = sysref_out_pkg::DELAY_W'(coarse_ps + sysref_out_pkg::fine_delay_ps(cfg.fine));
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '{drv: sysref_out_pkg::OUT_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign drv = state_ff.drv;

endmodule

/* File: design/sysref_output_state_control.sv */
// Output state register bank for the seven reference-signal channels, APB slave.
// Assumes coarse delay, bias type and signal sources come from logic on the same clock.
//
// Contract
// - Three-bit fine delay per channel, reset zero
// - Fine codes decode to 0..160 ps table
// - Bias only when bias-type is one
// - Two-bit swing, 250 to 1000 mV
// - Power-down overrides format, enable and swing
// - Format bit: zero LVDS, one LVPECL
// - Disabled output held at logic low
// - Seven channels, every field read/write
// - Source select resets to reference pulse
//
// Register map, one 32-bit word per place
//   0x00 A0, 0x04 A1, 0x08 A2, 0x0c B0, 0x10 B1, 0x14 C, 0x18 D: channel config words
//   0x1c status, read only: bits 6:0 powered flags, bit 8 global bias type
// Config word layout
//   2:0 fine delay code, 3 source select, 4 bias on, 5 format,
//   7:6 swing, 8 power-down, 9 enable; bits 31:10 read as zero
// Timing
//   Zero wait states: read data is caught at the setup edge and stands
//   until the next read setup; writes land at the access edge.
//   Channel outputs follow one cycle after the word is stored.
// Limitations
//   Bias is stored as written even for LVPECL; software keeps it legal.
//   Partial writes only see byte lanes 0 and 1.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
module sysref_output_state_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sysref_out_pkg::ADDR_W-1:0] paddr,
  input wire logic [sysref_out_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [sysref_out_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel neighbours
  input wire logic [sysref_out_pkg::NUM_CH-1:0][2:0] coarse_delay,
  input wire logic bias_type,
  input wire logic [sysref_out_pkg::NUM_CH-1:0] own_clock,
  input wire logic sysref_pulse,
  // Effective driver control
  output sysref_out_pkg::chan_out_t [sysref_out_pkg::NUM_CH-1:0] sysref_output_channel
);

  localparam int NCH = sysref_out_pkg::NUM_CH;

  typedef struct packed {
    sysref_out_pkg::chan_cfg_t [NCH-1:0] cfg;
    logic [sysref_out_pkg::DATA_W-1:0] rdata;
  } bank_state_t;

  bank_state_t state_ff;
  bank_state_t nxt_state;

  logic setup_phase;
  logic access_phase;
  logic hit_cfg;
  logic hit_status;
  logic [2:0] word_idx;
  logic [sysref_out_pkg::CFG_W-1:0] merged_word;
  logic [NCH-1:0] ch_powered;
  logic [sysref_out_pkg::DATA_W-1:0] read_word;
  logic [NCH-1:0] rd_sel;
  logic [NCH-1:0] wr_sel;
  logic wr_fire;

  // Bus phase and address decode
  // Word index can reach 7, the status slot, so the channel array
  // is only ever reached through the one-hot select below.
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign word_idx = paddr[sysref_out_pkg::WORD_LSB +: 3];
  assign hit_cfg = (paddr >= sysref_out_pkg::CFG_BASE_ADDR) && (paddr <= sysref_out_pkg::CFG_LAST_ADDR)
                   && (paddr[1:0] == 2'h0);
  assign hit_status = (paddr == sysref_out_pkg::STATUS_ADDR);
  assign wr_fire = access_phase & pwrite & hit_cfg;

  // One-hot channel select per config word
  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_sel
      assign rd_sel[ch] = hit_cfg && (word_idx == 3'(ch));
      assign wr_sel[ch] = wr_fire && rd_sel[ch];
    end
  endgenerate

  // Byte lanes merged into the addressed channel word; only two lanes carry bits
  // Lane 0 holds fine, source, bias, format and swing; lane 1 power-down and enable.
  // Lanes 2 and 3 are taken but dropped, as bits 31:10 do not exist.
  always_comb begin
    merged_word = '0;
    for (int i = 0; i < NCH; i++) begin
      if (rd_sel[i]) begin
        merged_word = state_ff.cfg[i];
      end
    end
    if (pstrb[0]) begin
      merged_word[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      merged_word[sysref_out_pkg::CFG_W-1:8] = pwdata[sysref_out_pkg::CFG_W-1:8];
    end
  end

  // Powered flags for the status word
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_powered[i] = sysref_output_channel[i].powered;
    end
  end

  // Read mux; unmapped reads return zero
  // Status shows the registered outputs, so it trails a write by one cycle
  always_comb begin
    read_word = '0;
    if (hit_status) begin
      read_word[NCH-1:0] = ch_powered;
      read_word[sysref_out_pkg::STATUS_BIAS_TYPE_BIT] = bias_type;
    end
    for (int i = 0; i < NCH; i++) begin
      if (rd_sel[i]) begin
        read_word[sysref_out_pkg::CFG_W-1:0] = state_ff.cfg[i];
      end
    end
  end

  // Next state: read data caught at setup, writes land at the access edge
  // Catching at setup lets the slave answer with no wait state
  always_comb begin
    nxt_state = state_ff;
    if (setup_phase && !pwrite) begin
      nxt_state.rdata = read_word;
    end
    for (int i = 0; i < NCH; i++) begin
      if (wr_sel[i]) begin
        nxt_state.cfg[i] = sysref_out_pkg::chan_cfg_t'(merged_word);
      end
    end
  end

  // State register; every channel loads its defaults at reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff.cfg <= {NCH{sysref_out_pkg::CFG_RESET}};
      state_ff.rdata <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Zero-wait slave: answer in the first access cycle
  assign pready = 1'h1;
  assign pslverr = access_phase & ~hit_cfg & (pwrite | ~hit_status);
  assign prdata = state_ff.rdata;

  // One gate per channel: A0, A1, A2, B0, B1, C, D
  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      sysref_chan_gate u_gate (
        .clock(clock),
        .rstn(rstn),
        .cfg(state_ff.cfg[ch]),
        .coarse_delay(coarse_delay[ch]),
        .bias_type(bias_type),
        .own_clock(own_clock[ch]),
        .sysref_pulse(sysref_pulse),
        .drv(sysref_output_channel[ch])
      );
    end
  endgenerate

  // Bias is not checked against format; keeping it to AC-coupled LVDS is left to software

endmodule

/* File: verification/sysref_out_props.sv */
// Port-level assertions for the reference-signal output bank.
// Assumes one clock domain; bound onto every bank instance.
`timescale 1ns/1ns
module sysref_out_props (
  // Clock
  input wire logic clock,
  input wire logic rstn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Channels
  input wire logic [6:0][2:0] coarse_delay,
  input wire logic bias_type,
  input wire logic [6:0] own_clock,
  input wire logic sysref_pulse,
  input wire sysref_out_pkg::chan_out_t [6:0] sysref_output_channel
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Short aliases keep properties readable
  sysref_out_pkg::chan_out_t [6:0] o;
  logic [6:0] pw;
  wire rd = psel && !penable && !pwrite;
  wire acc = psel && penable;
  assign o = sysref_output_channel;
  for (genvar c = 0; c < 7; c++) begin : g_ch
    assign pw[c] = o[c].powered;
    pd_clears_a: assert property (!o[c].powered |-> o[c] == '0)
      else $error("powered-down channel not cleared");
    fine_sum_a: assert property (o[c].powered |->
      int'(o[c].delay_ps) - 169 * $past(coarse_delay[c]) inside {0, 25, 50, 75, 85, 110, 135, 160})
      else $error("delay off the step table");
    src_level_a: assert property (o[c].level |-> $past(own_clock[c]) || $past(sysref_pulse))
      else $error("level high with low source");
    bias_gate_a: assert property (o[c].bias_active |-> $past(bias_type))
      else $error("bias without bias type");
  end
  // Refused places: unmapped, misaligned, beyond the status word
  bad_addr_a: assert property (acc && (paddr > 8'h1c || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("bad address not refused");
  cfg_ok_a: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("config access refused");
  cfg_read_a: assert property (rd && paddr <= 8'h18 |=> prdata[31:10] == 22'h0)
    else $error("config read upper bits set");
  status_read_a: assert property (rd && paddr == 8'h1c |=> prdata[8:0] == {$past(bias_type), 1'b0, $past(pw)})
    else $error("status word wrong");
  cover property (pw != 7'h7f);
  cover property (acc && pslverr);
  cover property (rd && paddr == 8'h1c);
endmodule

bind sysref_output_state_control sysref_out_props u_props (.*);

/* File: verification/sysref_output_state_control_bench.sv */
// Self-checking bench for the reference-signal output bank.
// Assumes zero-wait APB answers; inputs change right after rising edges.
`timescale 1ns/1ns
module sysref_output_state_control_bench;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, bias_type, sysref_pulse, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic [6:0][2:0] coarse_delay;
  logic [6:0] own_clock, pw;
  sysref_out_pkg::chan_out_t [6:0] sysref_output_channel;
  logic [9:0] sh [7];
  logic [9:0] w;
  logic [7:0] bad [4] = '{8'h20, 8'h02, 8'hfc, 8'h1c};
  int seed = 32'hf8a7bd5e;
  int fails, num_checks, ch;

  sysref_output_state_control DUT (.*);

  // 125 MHz clock
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end

  // Expected control: power-down wins, then enable, then shaping
  function automatic sysref_out_pkg::chan_out_t model(logic [9:0] w, logic [2:0] c, logic bt, logic oc, logic sp);
    logic [10:0] f [8] = '{0, 25, 50, 75, 85, 110, 135, 160};
    return w[8] ? '0 : {1'b1, w[9] & (w[3] ? sp : oc), w[5], w[7:6], w[4] & bt, 11'(c * 169) + f[w[2:0]]};
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One transfer; request held until pready is sampled high
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock);
      if (n == 0)
        chk("pready", 1, pready);
      if (pready === 1'b1) begin
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        return;
      end
    end
    fails++;
    conclude();
  endtask

  // Outputs one cycle after the store, then every word read back
  task automatic check_chans;
    @(posedge clock);
    #1;
    for (int c = 0; c < 7; c++) begin
      chk("channel", model(sh[c], coarse_delay[c], bias_type, own_clock[c], sysref_pulse), sysref_output_channel[c]);
      xfer(0, 8'(c * 4), 0);
      chk("config", {22'h0, sh[c]}, r);
      pw[c] = !sh[c][8];
    end
    xfer(0, 8'h1c, 0);
    chk("status", {23'h0, bias_type, 1'b0, pw}, r);
  endtask

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, bias_type, sysref_pulse, coarse_delay, own_clock} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1;
    sh = '{default: 10'h008};
    check_chans();
    // Coprime strides give each channel every fine code
    for (int i = 0; i < 70; i++) begin
      @(posedge clock);
      coarse_delay <= 21'($random(seed));
      own_clock <= 7'($random(seed));
      {bias_type, sysref_pulse} <= 2'($random(seed));
      ch = i % 7;
      w = 10'($random(seed));
      w[2:0] = 3'(i);
      if (w[5])
        w[4] = 1'b0;
      xfer(1, 8'(ch * 4), {22'($random(seed)), w});
      sh[ch] = w;
      check_chans();
    end
    // Refused places must leave every word untouched
    for (int k = 0; k < 4; k++) begin
      xfer(1, bad[k], '1);
      chk("write error", 1, e);
      xfer(0, bad[k], 0);
      chk("read error", 32'(k < 3), e);
      if (k < 3)
        chk("read data", 0, r);
    end
    // Byte lanes: lane 0 alone, lane 1 alone, then none
    pstrb <= 4'h1;
    xfer(1, 8'h00, 32'h0000_03a5);
    sh[0][7:0] = 8'ha5;
    pstrb <= 4'h2;
    xfer(1, 8'h00, 32'h0000_0200);
    sh[0][9:8] = 2'h2;
    pstrb <= 4'h0;
    xfer(1, 8'h00, 32'h0000_03ff);
    pstrb <= 4'hf;
    check_chans();
    // Mid-run reset restores every default
    @(posedge clock);
    rstn <= 0;
    @(posedge clock);
    rstn <= 1;
    sh = '{default: 10'h008};
    check_chans();
    conclude();
  end
endmodule
